// *** sim/aicm_afe_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Analog front end: mux, DAC and comparator
// ****************************************
module aicm_afe_model (
    input  wire logic [aicm_pkg::CH_W-1:0]                    mux_sel,
    input  wire logic [aicm_pkg::CODE_W-1:0]                  dac_code,
    input  wire logic [aicm_pkg::NCH-1:0][aicm_pkg::CODE_W-1:0] level,
    output logic                                              comp_above
);
    import aicm_pkg::*;

    // linear compare
    // Ideal comparator, so a settled conversion returns the level exactly
    always_comb begin
        comp_above = (level[mux_sel] >= dac_code);
    end
endmodule
`default_nettype wire

// *** sim/tb_analog_input_channel_mux.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_analog_input_channel_mux;
    import aicm_pkg::*;

    logic                         clk;
    logic                         nrst;
    logic                         scan_tick;
    logic                         top_control_point;
    logic                         chan_sel_lo;
    logic                         chan_sel_hi;
    logic                         comp_above;
    logic [CODE_W-1:0]            result_data;
    logic [CODE_W-1:0]            dac_code;
    logic [NCH-1:0]               active_ind;
    logic [CH_W-1:0]              adc_mux_sel;
    logic [NCH-1:0][CODE_W-1:0]   level;
    int                           err_count;
    int                           total_checks;
    int                           cur_ch;
    logic                         prev_all;

    aicm_top u_aicm_top (
        .clk               (clk),
        .nrst              (nrst),
        .scan_tick         (scan_tick),
        .top_control_point (top_control_point),
        .chan_sel_lo       (chan_sel_lo),
        .chan_sel_hi       (chan_sel_hi),
        .comp_above        (comp_above),
        .result_data       (result_data),
        .active_ind        (active_ind),
        .adc_mux_sel       (adc_mux_sel),
        .dac_code          (dac_code)
    );

    aicm_afe_model u_aicm_afe_model (
        .mux_sel    (adc_mux_sel),
        .dac_code   (dac_code),
        .level      (level),
        .comp_above (comp_above)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Host scan; controls settle through the synchroniser before the tick rises
    task automatic do_scan(input logic all, input logic [1:0] sel);
        top_control_point = all;
        chan_sel_lo = sel[0];
        chan_sel_hi = sel[1];
        step(3);
        scan_tick = 1'b1;
        step(4);
        scan_tick = 1'b0;
        step(2);
        if (all) begin
            cur_ch = prev_all ? (cur_ch + 1) % NCH : 0;
        end else begin
            cur_ch = sel;
        end
        prev_all = all;
    endtask

    task automatic scan_check(input logic all, input logic [1:0] sel);
        do_scan(all, sel);
        check_byte("result_data", level[cur_ch], result_data);
        check_byte("active_ind", 8'(1 << cur_ch), 8'(active_ind));
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h7d21));
        err_count = 0;
        total_checks = 0;
        cur_ch = 0;
        prev_all = 1'b0;
        nrst = 1'b0;
        scan_tick = 1'b0;
        top_control_point = 1'b1;
        chan_sel_lo = 1'b0;
        chan_sel_hi = 1'b0;
        level[0] = 8'h00;
        level[1] = 8'hff;
        level[2] = 8'($urandom);
        level[3] = 8'($urandom);
        step(5);
        nrst = 1'b1;
        // Nothing converted yet, so no indicator may be raised
        do_scan(1'b1, 2'h3);
        check_byte("active_ind", 8'h00, 8'(active_ind));
        check_byte("result_data", 8'h00, result_data);
        // Background conversion of all four channels
        step(4000);
        for (int i = 0; i < 6; i++) begin
            scan_check(1'b1, 2'($urandom));
        end
        for (int s = 0; s < NCH; s++) begin
            top_control_point = 1'b0;
            chan_sel_lo = 1'(s);
            chan_sel_hi = 1'(s >> 1);
            // A conversion already under way finishes before the new channel starts
            step(2000);
            check_byte("adc_mux_sel", 8'(s), 8'(adc_mux_sel));
            scan_check(1'b0, 2'(s));
        end
        // Level change while the host is not scanning
        top_control_point = 1'b0;
        chan_sel_lo = 1'b0;
        chan_sel_hi = 1'b1;
        level[2] = 8'($urandom);
        step(2000);
        scan_check(1'b0, 2'h2);
        scan_check(1'b0, 2'h2);
        scan_check(1'b1, 2'h2);
        scan_check(1'b1, 2'h0);
        complete_run();
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire

// *** src/aicm_buf.sv ***
`timescale 1ns/100ps
`default_nettype none
module aicm_buf #(
    parameter int W = aicm_pkg::BUF_W
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import aicm_pkg::*;

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } aicm_buf_t;

    aicm_buf_t r;
    aicm_buf_t next_r;

    logic push;
    logic pop;

    assign in_ready  = (r.cnt != 2'h2);
    assign out_valid = (r.cnt != 2'h0);
    assign out_data  = r.mem[r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp        = ~r.wp;
        end
        if (pop) begin
            next_r.rp = ~r.rp;
        end
        next_r.cnt = 2'(r.cnt + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // A full buffer must keep both words while the producer waits
    buf_full_stall_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.cnt == 2'h2 && in_valid && !out_ready) |=> $stable(r.mem))
        else $error("buffer overwrote a stored word while full");

endmodule
`default_nettype wire

// *** src/aicm_pkg.sv ***
package aicm_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCH    = 4;
    localparam int CH_W   = 2;
    localparam int CODE_W = 8;
    localparam int BUF_W  = CH_W + CODE_W;

    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [CODE_W-1:0] CODE_ZERO  = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MSB   = 8'h80;
    localparam logic [2:0]        BIT_TOP    = 3'h7;
    localparam logic [CH_W-1:0]   CH_FIRST   = 2'h0;
    localparam logic [NCH-1:0]    MASK_ALL   = 4'hf;
    localparam logic [NCH-1:0]    MASK_ONE   = 4'h1;
    localparam logic [NCH-1:0]    IND_NONE   = 4'h0;

    // ****************************************
    // Synchroniser bit positions
    // ****************************************
    localparam int SY_W    = 5;
    localparam int SY_COMP = 0;
    localparam int SY_LO   = 1;
    localparam int SY_HI   = 2;
    localparam int SY_ALL  = 3;
    localparam int SY_TICK = 4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SETTLE_NS     = 500;
    localparam int SETTLE_CYC_I  = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_I);
    localparam logic [7:0] CNT_ZERO   = 8'h00;

    // Next enabled channel above cur, wrapping; cur when none enabled
    function automatic logic [CH_W-1:0] aicm_next_ch(input logic [CH_W-1:0] cur,
                                                     input logic [NCH-1:0]  mask);
        logic [CH_W-1:0] cand;
        logic [CH_W-1:0] res;
        logic            found;
        res   = cur;
        found = 1'b0;
        for (int i = 1; i <= NCH; i++) begin
            cand = CH_W'(cur + CH_W'(i));
            if (!found && mask[cand]) begin
                res   = cand;
                found = 1'b1;
            end
        end
        return res;
    endfunction

endpackage

// *** src/aicm_sar.sv ***
`timescale 1ns/100ps
`default_nettype none
module aicm_sar (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        comp_above,
    input  wire logic [aicm_pkg::NCH-1:0]    ch_mask,
    output logic      [aicm_pkg::CH_W-1:0]   mux_sel,
    output logic      [aicm_pkg::CODE_W-1:0] dac_code,
    output logic                             res_valid,
    input  wire logic                        res_ready,
    output logic      [aicm_pkg::BUF_W-1:0]  res_data
);
    import aicm_pkg::*;

    typedef enum logic [1:0] {SAR_START, SAR_BIT, SAR_PUSH} aicm_sar_st_t;

    typedef struct packed {
        aicm_sar_st_t      st;
        logic [CH_W-1:0]   ch;
        logic [CODE_W-1:0] code;
        logic [2:0]        bitp;
        logic [7:0]        cnt;
    } aicm_sar_t;

    aicm_sar_t r;
    aicm_sar_t next_r;

    assign mux_sel   = r.ch;
    assign dac_code  = r.code;
    assign res_valid = (r.st == SAR_PUSH);
    assign res_data  = {r.ch, r.code};

    always_comb begin
        next_r = r;
        unique case (r.st)
            SAR_START: begin
                next_r.code = CODE_MSB;
                next_r.bitp = BIT_TOP;
                next_r.cnt  = SETTLE_CYC;
                next_r.st   = SAR_BIT;
            end
            SAR_BIT: begin
                if (r.cnt != CNT_ZERO) begin
                    next_r.cnt = 8'(r.cnt - 8'h01);
                end else begin
                    if (!comp_above) begin
                        next_r.code[r.bitp] = 1'b0;
                    end
                    if (r.bitp == 3'h0) begin
                        next_r.st = SAR_PUSH;
                    end else begin
                        next_r.bitp                = 3'(r.bitp - 3'h1);
                        next_r.code[r.bitp - 3'h1] = 1'b1;
                        next_r.cnt                 = SETTLE_CYC;
                    end
                end
            end
            SAR_PUSH: begin
                if (res_ready) begin
                    next_r.ch = aicm_next_ch(r.ch, ch_mask);
                    next_r.st = SAR_START;
                end
            end
            default: begin
                next_r.st = SAR_START;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '{st: SAR_START, ch: CH_FIRST, code: CODE_ZERO, bitp: BIT_TOP, cnt: CNT_ZERO};
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Msb trial first, one trial per code bit
    sar_first_trial_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.st == SAR_START) |=> (r.code == CODE_MSB && r.bitp == BIT_TOP))
        else $error("conversion does not start at mid scale");

    // Converter never parks in start
    sar_keeps_running_a: assert property (@(posedge clk) disable iff (!nrst)
        (r.st == SAR_START) |=> (r.st == SAR_BIT))
        else $error("converter stalled in start");

endmodule
`default_nettype wire

// *** src/aicm_top.sv ***
// Notes on behaviour
// - One channel result handed over per scan
// - Ascending channel order, wrap to channel one
// - Unselected channels skipped in rotation
// - Conversion runs continuously, independent of scan
// - Scan-all is top point, driven by host
// - Scan-all on: all four channels rotate
// - Scan-all off: only selected channel reported
// - Select points form binary index, low bit0
// - Select points ignored while scan-all on
// - Four one-hot active-channel inputs to host
// - Data byte unsigned binary, bit0 weight one
// - Range low gives 0, high 255
// - One code step is span over 255
`timescale 1ns/100ps
`default_nettype none
module aicm_top (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        scan_tick,
    input  wire logic                        top_control_point,
    input  wire logic                        chan_sel_lo,
    input  wire logic                        chan_sel_hi,
    input  wire logic                        comp_above,
    output logic      [aicm_pkg::CODE_W-1:0] result_data,
    output logic      [aicm_pkg::NCH-1:0]    active_ind,
    output logic      [aicm_pkg::CH_W-1:0]   adc_mux_sel,
    output logic      [aicm_pkg::CODE_W-1:0] dac_code
);
    import aicm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [SY_W-1:0]             s1;
        logic [SY_W-1:0]             s2;
        logic                        tick_d;
        logic                        all_d;
        logic [CH_W-1:0]             ch;
        logic [NCH-1:0][CODE_W-1:0]  res;
        logic [NCH-1:0]              vld;
        logic [CODE_W-1:0]           data;
        logic [NCH-1:0]              ind;
    } aicm_top_t;

    aicm_top_t r;
    aicm_top_t next_r;

    logic                  scan_edge;
    logic                  scan_all;
    logic [CH_W-1:0]       sel;
    logic [NCH-1:0]        mask;
    logic [CH_W-1:0]       ch_new;
    logic                  cv_valid;
    logic                  cv_ready;
    logic [BUF_W-1:0]      cv_data;
    logic                  bf_valid;
    logic                  bf_ready;
    logic [BUF_W-1:0]      bf_data;
    logic [CH_W-1:0]       bf_ch;

    assign scan_edge = r.s2[SY_TICK] && !r.tick_d;
    // scan-all taken from the top point
    assign scan_all  = r.s2[SY_ALL];
    // binary channel index, low select bit0
    assign sel       = {r.s2[SY_HI], r.s2[SY_LO]};
    assign mask      = scan_all ? MASK_ALL : NCH'(MASK_ONE << sel);
    // Store side stalls in the handover cycle so a result never races the scan
    assign bf_ready  = !scan_edge;
    assign bf_ch     = bf_data[BUF_W-1 -: CH_W];

    // ascending order with wrap; restart at channel one
    always_comb begin
        if (!scan_all) begin
            ch_new = sel;
        end else if (!r.all_d) begin
            ch_new = CH_FIRST;
        end else begin
            ch_new = aicm_next_ch(r.ch, mask);
        end
    end

    always_comb begin
        next_r        = r;
        next_r.s1     = {scan_tick, top_control_point, chan_sel_hi, chan_sel_lo, comp_above};
        next_r.s2     = r.s1;
        next_r.tick_d = r.s2[SY_TICK];
        if (bf_valid && bf_ready) begin
            next_r.res[bf_ch] = bf_data[CODE_W-1:0];
            next_r.vld[bf_ch] = 1'b1;
        end
        if (scan_edge) begin
            next_r.all_d = scan_all;
            next_r.ch    = ch_new;
            // plain unsigned code on the data byte
            next_r.data  = r.res[ch_new];
            // one-hot indicator; none until a result exists
            // indicator qualifies the shared data byte
            next_r.ind   = r.vld[ch_new] ? NCH'(MASK_ONE << ch_new) : IND_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign result_data = r.data;
    assign active_ind  = r.ind;

    // ****************************************
    // Converter and buffer
    // ****************************************
    // converter sees the synchronised comparator, the mask and the buffer ready
    aicm_sar u_sar (
        .clk        (clk),
        .nrst       (nrst),
        .comp_above (r.s2[SY_COMP]),
        .ch_mask    (mask),
        .mux_sel    (adc_mux_sel),
        .dac_code   (dac_code),
        .res_valid  (cv_valid),
        .res_ready  (cv_ready),
        .res_data   (cv_data)
    );

    aicm_buf #(
        .W (BUF_W)
    ) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (cv_valid),
        .in_ready  (cv_ready),
        .in_data   (cv_data),
        .out_valid (bf_valid),
        .out_ready (bf_ready),
        .out_data  (bf_data)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    ind_one_hot_a: assert property ($onehot0(active_ind))
        else $error("indicators not one-hot");

    ind_on_scan_a: assert property ($changed(active_ind) |-> $past(scan_edge))
        else $error("indicators changed outside a scan edge");

    rot_wrap_a: assert property ((scan_edge && scan_all && r.all_d && r.ch == 2'h3) |=> (r.ch == 2'h0))
        else $error("rotation did not wrap to channel one");

    rot_ascend_a: assert property ((scan_edge && scan_all && r.all_d) |=> (r.ch == 2'($past(r.ch) + 2'h1)))
        else $error("rotation skipped or repeated a channel");

    rot_start_a: assert property ((scan_edge && scan_all && !r.all_d) |=> (r.ch == CH_FIRST))
        else $error("rotation did not start at channel one");

    single_sel_a: assert property ((scan_edge && !scan_all) |=> (r.ch == $past(sel)))
        else $error("single channel differs from select points");

    data_match_a: assert property (scan_edge |=> (result_data == $past(r.res[ch_new])))
        else $error("data byte is not the channel result");

    ind_none_a: assert property ((scan_edge && !r.vld[ch_new]) |=> (active_ind == IND_NONE))
        else $error("indicator raised without a result");

    ind_match_a: assert property ((active_ind != IND_NONE) |-> active_ind[r.ch])
        else $error("indicator does not name the reported channel");

    all_cov_c: cover property (scan_edge && scan_all && r.all_d && r.ch == 2'h3);
    single_cov_c: cover property (scan_edge && !scan_all && sel == 2'h3);
    stall_cov_c: cover property (!cv_ready && cv_valid);

endmodule
`default_nettype wire
